/* File: hw/output_voltage_setpoint_params.svh */
`ifndef OUTPUT_VOLTAGE_SETPOINT_PARAMS_SVH
`define OUTPUT_VOLTAGE_SETPOINT_PARAMS_SVH

// Register offsets
`define OFS_SYS_CFG_USER_ONE    8'hA0
`define OFS_OUTPUT_VOLTAGE_CMD  8'hA6
`define OFS_HOST_OUTPUT_OFFSET  8'hA8
`define OFS_STEP_AND_BOOT       8'hC2

// Field positions
`define SRC_SEL_LSB   0
`define SRC_SEL_MSB   1
`define SRC_ACT_LSB   2
`define SRC_ACT_MSB   3
`define BOOT_LSB      0
`define BOOT_MSB      3
`define STEP_LSB      4
`define STEP_MSB      5

// Reset values
`define SRC_SEL_RST   2'h0
`define OUTPUT_VOLTAGE_COMMAND_RST  8'h01
`define HOST_OFS_RST  8'h00
`define BOOT_RST      4'h0
`define STEP_RST      2'h1
`define LINK_MAX_RST  9'h0FF

// Limits
`define OUTPUT_VOLTAGE_COMMAND_MIN  8'h01
`define HOST_MAX_CODE 9'h17E
`define BOOT_LAST_5MV 4'hC

`endif

/* File: hw/output_voltage_setpoint_pkg.sv */
package output_voltage_setpoint_pkg;

    typedef enum logic [2:0] {
        SRC_LINK = 3'b001,
        SRC_MIX  = 3'b010,
        SRC_HOST = 3'b100
    } source_e;

    typedef enum logic [2:0] {
        PH_OFF  = 3'b001,
        PH_RAMP = 3'b010,
        PH_RUN  = 3'b100
    } phase_e;

endpackage

/* File: hw/level_sync.sv */
`timescale 1ns/1ps

module level_sync (
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic din,
    output logic      dout
);

    logic stage_q;

    // First stage feeds only the second
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            stage_q <= 1'b0;
            dout    <= 1'b0;
        end else begin
            stage_q <= din;
            dout    <= stage_q;
        end
    end

endmodule

/* File: hw/output_voltage_setpoint_select.sv */
`timescale 1ns/1ps
`include "output_voltage_setpoint_params.svh"

module output_voltage_setpoint_select #(
    parameter int CODE_W = 8
) (
    input  wire logic              clk,
    input  wire logic              nrst,
    input  wire logic              enPin,
    input  wire logic              softStartDonePin,
    input  wire logic              regWrStb,
    input  wire logic              regRdStb,
    input  wire logic [7:0]        regAddr,
    input  wire logic [7:0]        regWrData,
    output logic                   regAck,
    output logic [7:0]             regRdData,
    input  wire logic              linkSetVoltageStb,
    input  wire logic              linkSetWorkingPointStb,
    input  wire logic [CODE_W-1:0] linkVoltageCode,
    input  wire logic              linkOffsetWrStb,
    input  wire logic [CODE_W-1:0] linkOffsetData,
    input  wire logic              linkMaxWrStb,
    input  wire logic [CODE_W:0]   linkMaxData,
    output logic                   linkAck,
    output logic [CODE_W-1:0]      linkBootCode,
    input  wire logic              storeAllStb,
    output logic                   nvmWrStb,
    output logic [3:0]             nvmBootOut,
    output logic [1:0]             nvmStepOut,
    output logic [CODE_W-1:0]      nvmVoutCmdOut,
    input  wire logic              nvmLoadStb,
    input  wire logic [3:0]        nvmBootIn,
    input  wire logic [1:0]        nvmStepIn,
    input  wire logic [CODE_W-1:0] nvmVoutCmdIn,
    output logic [CODE_W:0]        setpointCode,
    output logic                   step10mV,
    output logic                   divQuarter
);

    ////////////////////////////////////////////////////////////////////////////
    // Elaboration check

    generate
        if (CODE_W != 8) begin : g_bad_width
            $error("output_voltage_setpoint_select supports CODE_W of 8 only");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    logic                     enSync;
    logic                     ssDoneSync;
    logic                     en_q;
    logic                     enRise;
    logic [1:0]               srcSel_q;
    logic [CODE_W-1:0]        voutCmd_q;
    logic [CODE_W-1:0]        hostOffset_q;
    logic [3:0]               boot_q;
    logic [1:0]               step_q;
    output_voltage_setpoint_pkg::source_e activeSrc_q;
    output_voltage_setpoint_pkg::source_e curSrc;
    output_voltage_setpoint_pkg::phase_e  phase_q;
    logic [CODE_W-1:0]        mixOffset_q;
    logic [CODE_W-1:0]        linkOffset_q;
    logic [CODE_W:0]          linkMax_q;
    logic [CODE_W-1:0]        linkBoot_q;
    logic [CODE_W-1:0]        linkTarget_q;
    logic                     nvmWrStb_q;
    logic [3:0]               nvmBoot_q;
    logic [1:0]               nvmStep_q;
    logic [CODE_W-1:0]        nvmVoutCmd_q;
    logic [CODE_W:0]          setpoint_q;
    logic [7:0]               rdData_q;
    logic                     hitSys;
    logic                     hitVout;
    logic                     hitOfs;
    logic                     hitStep;
    logic                     comboOk;
    logic                     vcmdOk;
    logic                     wrVout;
    logic                     wrOfs;
    logic                     wrStep;
    logic                     linkSetStb;
    logic [3:0]               bootNew;
    logic [1:0]               stepNew;
    logic [CODE_W-1:0]        baseCode;
    logic [CODE_W-1:0]        offCode;
    logic [CODE_W:0]          limitCode;
    logic signed [CODE_W+1:0] sumCode;
    logic [CODE_W:0]          setpoint_d;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [7:0] boot_to_code(input logic [3:0] boot);
        logic [7:0] code;
        code = 8'h00;
        unique case (boot)
            4'h0: code = 8'h00;
            4'h1: code = 8'h65;
            4'h2: code = 8'h6F;
            4'h3: code = 8'h79;
            4'h4: code = 8'h83;
            4'h5: code = 8'h8D;
            4'h6: code = 8'h97;
            4'h7: code = 8'hA1;
            4'h8: code = 8'hAB;
            4'h9: code = 8'hAF;
            4'hA: code = 8'hC9;
            4'hB: code = 8'hDD;
            4'hC: code = 8'hFB;
            4'hD: code = 8'h6F;
            4'hE: code = 8'h79;
            4'hF: code = 8'h83;
        endcase
        return code;
    endfunction

    function automatic logic is5mV(input logic [1:0] step);
        return step[0] ^ step[1];
    endfunction

    function automatic output_voltage_setpoint_pkg::source_e decode_src(input logic [1:0] sel);
        output_voltage_setpoint_pkg::source_e src;
        src = output_voltage_setpoint_pkg::SRC_HOST;
        if (sel == 2'h0) begin
            src = output_voltage_setpoint_pkg::SRC_LINK;
        end else if (sel == 2'h1) begin
            src = output_voltage_setpoint_pkg::SRC_MIX;
        end
        return src;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    level_sync u_en_sync (
        .clk  (clk),
        .nrst (nrst),
        .din  (enPin),
        .dout (enSync)
    );

    level_sync u_ss_sync (
        .clk  (clk),
        .nrst (nrst),
        .din  (softStartDonePin),
        .dout (ssDoneSync)
    );

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            en_q <= 1'b0;
        end else begin
            en_q <= enSync;
        end
    end

    assign enRise = enSync & ~en_q;

    ////////////////////////////////////////////////////////////////////////////
    // Register write decode and acknowledge

    // Disabled: source follows the field so acks match the coming mode
    assign curSrc = enSync ? activeSrc_q : decode_src(srcSel_q);

    assign hitSys  = regAddr == `OFS_SYS_CFG_USER_ONE;
    assign hitVout = regAddr == `OFS_OUTPUT_VOLTAGE_CMD;
    assign hitOfs  = regAddr == `OFS_HOST_OUTPUT_OFFSET;
    assign hitStep = regAddr == `OFS_STEP_AND_BOOT;
    assign bootNew = regWrData[`BOOT_MSB:`BOOT_LSB];
    assign stepNew = regWrData[`STEP_MSB:`STEP_LSB];
    assign vcmdOk  = regWrData >= `OUTPUT_VOLTAGE_COMMAND_MIN;

    // Boot 0000b pairs with either step size
    assign comboOk = (bootNew == 4'h0) ||
                     ((bootNew <= `BOOT_LAST_5MV) == is5mV(stepNew));

    always_comb begin
        regAck = 1'b0;
        if (regWrStb) begin
            if (hitSys) begin
                regAck = 1'b1;
            end else if (hitVout) begin
                regAck = vcmdOk;
            end else if (hitOfs) begin
                regAck = curSrc != output_voltage_setpoint_pkg::SRC_LINK;
            end else if (hitStep) begin
                regAck = comboOk;
            end
        end
    end

    // Link-mode command writes are acked but do nothing
    assign wrVout = regWrStb & hitVout & vcmdOk &
                    (curSrc == output_voltage_setpoint_pkg::SRC_HOST);
    assign wrOfs  = regWrStb & hitOfs & (curSrc != output_voltage_setpoint_pkg::SRC_LINK);
    assign wrStep = regWrStb & hitStep & comboOk;

    ////////////////////////////////////////////////////////////////////////////
    // Host-side registers

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            srcSel_q <= `SRC_SEL_RST;
        end else if (regWrStb && hitSys) begin
            srcSel_q <= regWrData[`SRC_SEL_MSB:`SRC_SEL_LSB];
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            voutCmd_q <= `OUTPUT_VOLTAGE_COMMAND_RST;
        end else if (nvmLoadStb) begin
            voutCmd_q <= nvmVoutCmdIn;
        end else if (wrVout) begin
            voutCmd_q <= regWrData;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            hostOffset_q <= `HOST_OFS_RST;
        end else if (wrOfs) begin
            hostOffset_q <= regWrData;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            boot_q <= `BOOT_RST;
            step_q <= `STEP_RST;
        end else if (nvmLoadStb) begin
            boot_q <= nvmBootIn;
            step_q <= nvmStepIn;
        end else if (wrStep) begin
            boot_q <= bootNew;
            step_q <= stepNew;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mode latch and start-up phase

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            activeSrc_q <= output_voltage_setpoint_pkg::SRC_LINK;
            mixOffset_q <= '0;
        end else if (enRise) begin
            activeSrc_q <= decode_src(srcSel_q);
            mixOffset_q <= hostOffset_q;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            phase_q <= output_voltage_setpoint_pkg::PH_OFF;
        end else if (!enSync) begin
            phase_q <= output_voltage_setpoint_pkg::PH_OFF;
        end else begin
            unique case (phase_q)
                output_voltage_setpoint_pkg::PH_OFF: begin
                    phase_q <= output_voltage_setpoint_pkg::PH_RAMP;
                end
                output_voltage_setpoint_pkg::PH_RAMP: begin
                    if (ssDoneSync) begin
                        phase_q <= output_voltage_setpoint_pkg::PH_RUN;
                    end
                end
                output_voltage_setpoint_pkg::PH_RUN: begin
                    phase_q <= output_voltage_setpoint_pkg::PH_RUN;
                end
                default: begin
                    phase_q <= output_voltage_setpoint_pkg::PH_OFF;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Link-side registers

    assign linkSetStb = linkSetVoltageStb | linkSetWorkingPointStb;

    // Link writes are always taken; ignored ones simply store nothing
    assign linkAck = linkSetStb | linkOffsetWrStb | linkMaxWrStb;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            linkOffset_q <= '0;
        end else if (linkOffsetWrStb && curSrc == output_voltage_setpoint_pkg::SRC_LINK) begin
            linkOffset_q <= linkOffsetData;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            linkMax_q <= `LINK_MAX_RST;
        end else if (linkMaxWrStb) begin
            linkMax_q <= linkMaxData;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            linkBoot_q <= '0; // Boot 0000b decodes to code 00h
        end else if (nvmLoadStb) begin
            linkBoot_q <= boot_to_code(nvmBootIn);
        end else if (wrStep) begin
            linkBoot_q <= boot_to_code(bootNew);
        end
    end

    // Set commands only count once the ramp is over
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            linkTarget_q <= '0;
        end else if (enRise) begin
            linkTarget_q <= linkBoot_q;
        end else if (linkSetStb && phase_q == output_voltage_setpoint_pkg::PH_RUN &&
                     curSrc != output_voltage_setpoint_pkg::SRC_HOST) begin
            linkTarget_q <= linkVoltageCode;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Non-volatile store

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            nvmWrStb_q   <= 1'b0;
            nvmBoot_q    <= '0;
            nvmStep_q    <= '0;
            nvmVoutCmd_q <= '0;
        end else begin
            nvmWrStb_q <= storeAllStb;
            if (storeAllStb) begin
                nvmBoot_q    <= boot_q;
                nvmStep_q    <= step_q;
                nvmVoutCmd_q <= voutCmd_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Setpoint arithmetic

    always_comb begin
        baseCode  = (phase_q == output_voltage_setpoint_pkg::PH_OFF) ? linkBoot_q : linkTarget_q;
        offCode   = '0;
        limitCode = linkMax_q;
        unique case (curSrc)
            output_voltage_setpoint_pkg::SRC_LINK: begin
                offCode = enSync ? linkOffset_q : '0;
            end
            output_voltage_setpoint_pkg::SRC_MIX: begin
                offCode = mixOffset_q;
            end
            output_voltage_setpoint_pkg::SRC_HOST: begin
                baseCode  = voutCmd_q;
                offCode   = hostOffset_q;
                limitCode = `HOST_MAX_CODE;
            end
        endcase
        sumCode = $signed({2'b00, baseCode}) +
                  $signed({{2{offCode[CODE_W-1]}}, offCode});
        if (sumCode < 0) begin
            setpoint_d = '0;
        end else if (sumCode[CODE_W:0] > limitCode) begin
            setpoint_d = limitCode;
        end else begin
            setpoint_d = sumCode[CODE_W:0];
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            setpoint_q <= '0;
        end else begin
            setpoint_q <= setpoint_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdData_q <= 8'h00;
        end else if (regRdStb) begin
            rdData_q <= 8'h00;
            if (hitSys) begin
                rdData_q[`SRC_SEL_MSB:`SRC_SEL_LSB] <= srcSel_q;
                rdData_q[`SRC_ACT_MSB:`SRC_ACT_LSB] <=
                    (curSrc == output_voltage_setpoint_pkg::SRC_LINK) ? 2'h0 :
                    (curSrc == output_voltage_setpoint_pkg::SRC_MIX)  ? 2'h1 : 2'h2;
            end else if (hitVout) begin
                rdData_q <= voutCmd_q;
            end else if (hitOfs) begin
                rdData_q <= hostOffset_q;
            end else if (hitStep) begin
                rdData_q[`BOOT_MSB:`BOOT_LSB] <= boot_q;
                rdData_q[`STEP_MSB:`STEP_LSB] <= step_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign regRdData     = rdData_q;
    assign linkBootCode  = linkBoot_q;
    assign nvmWrStb      = nvmWrStb_q;
    assign nvmBootOut    = nvmBoot_q;
    assign nvmStepOut    = nvmStep_q;
    assign nvmVoutCmdOut = nvmVoutCmd_q;
    assign setpointCode  = setpoint_q;
    assign step10mV      = ~is5mV(step_q);
    assign divQuarter    = ~is5mV(step_q);

endmodule

/* File: tb/output_voltage_setpoint_select_chk.sv */
`timescale 1ns/1ps
module output_voltage_setpoint_select_chk #(
    parameter int CODE_W = 8
) (
    input wire logic              clk,
    input wire logic              nrst,
    input wire logic              regWrStb,
    input wire logic [7:0]        regAddr,
    input wire logic [7:0]        regWrData,
    input wire logic              regAck,
    input wire logic              linkSetVoltageStb,
    input wire logic              linkSetWorkingPointStb,
    input wire logic              linkOffsetWrStb,
    input wire logic              linkAck,
    input wire logic [CODE_W-1:0] linkBootCode,
    input wire logic              storeAllStb,
    input wire logic              nvmWrStb,
    input wire logic              nvmLoadStb,
    input wire logic [3:0]        nvmBootIn,
    input wire logic              step10mV,
    input wire logic              divQuarter
);
    localparam logic [7:0] BOOT_CODE [16] = '{8'h00, 8'h65, 8'h6F, 8'h79, 8'h83, 8'h8D,
        8'h97, 8'hA1, 8'hAB, 8'hAF, 8'hC9, 8'hDD, 8'hFB, 8'h6F, 8'h79, 8'h83};
    logic [3:0] wrBoot;
    logic [1:0] wrStep;
    logic       c2Wr;
    logic       pairOk;
    logic [3:0] lastBoot_q;
    assign wrBoot = regWrData[3:0];
    assign wrStep = regWrData[5:4];
    assign c2Wr   = regWrStb && regAddr == 8'hC2;
    assign pairOk = wrBoot == 4'h0 || ((wrBoot <= 4'hC) == (wrStep inside {2'h1, 2'h2}));
    // Shadow of the boot field, so the link copy can be checked up to two cycles after the write or load
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            lastBoot_q <= 4'h0;
        else if (nvmLoadStb)
            lastBoot_q <= nvmBootIn;
        else if (c2Wr && regAck)
            lastBoot_q <= wrBoot;
    end
    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    step_divider_a: assert property ((c2Wr && regAck && !nvmLoadStb) |=>
        step10mV == ($past(wrStep) inside {2'h0, 2'h3}) && divQuarter == step10mV)
        else $error("step or divider wrong after step write");
    zero_cmd_nack_a: assert property ((regWrStb && regAddr == 8'hA6
        && regWrData == 8'h00) |-> !regAck) else $error("zero command acked");
    boot_pair_ack_a: assert property (c2Wr |-> regAck == pairOk)
        else $error("boot and step pairing answer wrong");
    link_ack_a: assert property ((linkSetVoltageStb || linkSetWorkingPointStb
        || linkOffsetWrStb) |-> linkAck) else $error("link write not acked");
    store_pulse_a: assert property (storeAllStb |=> nvmWrStb)
        else $error("store not passed to memory");
    store_cause_a: assert property (nvmWrStb |-> $past(storeAllStb))
        else $error("memory write without store");
    boot_copy_a: assert property ($changed(lastBoot_q) |-> ##[0:1]
        linkBootCode == BOOT_CODE[lastBoot_q]) else $error("link boot copy wrong");
    boot_reload_a: assert property (nvmLoadStb |-> ##[1:2]
        linkBootCode == BOOT_CODE[lastBoot_q]) else $error("link boot reload wrong");
    cover property (c2Wr && !regAck);
    cover property (nvmLoadStb);
    cover property (linkSetVoltageStb && linkAck);
endmodule

bind output_voltage_setpoint_select output_voltage_setpoint_select_chk #(.CODE_W(CODE_W)) spChk (.*);

/* File: tb/output_voltage_far_side.sv */
`timescale 1ns/1ps
module output_voltage_far_side #(
    parameter int RAMP_CYC = 6
) (
    input  wire logic       clk,
    input  wire logic       enPin,
    output logic            softStartDonePin,
    output logic            linkSetVoltageStb,
    output logic            linkSetWorkingPointStb,
    output logic [7:0]      linkVoltageCode,
    output logic            linkOffsetWrStb,
    output logic [7:0]      linkOffsetData,
    output logic            linkMaxWrStb,
    output logic [8:0]      linkMaxData,
    input  wire logic       nvmWrStb,
    input  wire logic [3:0] nvmBootOut,
    input  wire logic [1:0] nvmStepOut,
    input  wire logic [7:0] nvmVoutCmdOut,
    output logic            nvmLoadStb,
    output logic [3:0]      nvmBootIn,
    output logic [1:0]      nvmStepIn,
    output logic [7:0]      nvmVoutCmdIn
);
    logic [13:0] mem;
    int          rampCnt;
    initial begin
        {linkSetVoltageStb, linkSetWorkingPointStb, linkOffsetWrStb, linkMaxWrStb} = 4'h0;
        {linkVoltageCode, linkOffsetData, linkMaxData} = '0;
        {nvmLoadStb, nvmBootIn, nvmStepIn, nvmVoutCmdIn} = '0;
        mem = {4'h0, 2'h1, 8'h01};
        softStartDonePin = 1'b0;
        rampCnt = 0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Ramp ends a fixed time after enable, drops at once when enable falls
    always @(negedge clk) begin
        if (!enPin) begin
            rampCnt = 0;
            softStartDonePin = 1'b0;
        end else if (rampCnt < RAMP_CYC) begin
            rampCnt++;
        end else begin
            softStartDonePin = 1'b1;
        end
    end
    always @(posedge clk) begin
        if (nvmWrStb)
            mem <= {nvmBootOut, nvmStepOut, nvmVoutCmdOut};
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Released data lines flip, so a stale value is never mistaken for a live one
    task automatic send(input int kind, input logic [8:0] val);
        @(negedge clk);
        {linkSetVoltageStb, linkSetWorkingPointStb} = {kind == 0, kind == 1};
        {linkOffsetWrStb, linkMaxWrStb} = {kind == 2, kind == 3};
        {linkVoltageCode, linkOffsetData, linkMaxData} = {val[7:0], val[7:0], val};
        @(negedge clk);
        {linkSetVoltageStb, linkSetWorkingPointStb, linkOffsetWrStb, linkMaxWrStb} = 4'h0;
        {linkVoltageCode, linkOffsetData, linkMaxData} = ~{val[7:0], val[7:0], val};
    endtask
    task automatic reload();
        @(negedge clk);
        nvmLoadStb = 1'b1;
        {nvmBootIn, nvmStepIn, nvmVoutCmdIn} = mem;
        @(negedge clk);
        nvmLoadStb = 1'b0;
        {nvmBootIn, nvmStepIn, nvmVoutCmdIn} = ~mem;
    endtask
endmodule

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    logic clk, nrst, enPin, softStartDonePin, regWrStb, regRdStb, regAck, storeAllStb;
    logic linkSetVoltageStb, linkSetWorkingPointStb, linkOffsetWrStb, linkMaxWrStb, linkAck;
    logic nvmWrStb, nvmLoadStb, step10mV, divQuarter;
    logic [7:0] regAddr, regWrData, regRdData, linkVoltageCode, linkOffsetData, linkBootCode;
    logic [7:0] nvmVoutCmdOut, nvmVoutCmdIn, v;
    logic [8:0] linkMaxData, setpointCode, e;
    logic [3:0] nvmBootOut, nvmBootIn;
    logic [1:0] nvmStepOut, nvmStepIn;
    logic [31:0] r, seed;
    int fails, compares;
    localparam logic [7:0] BOOT_CODE [16] = '{8'h00, 8'h65, 8'h6F, 8'h79, 8'h83, 8'h8D,
        8'h97, 8'hA1, 8'hAB, 8'hAF, 8'hC9, 8'hDD, 8'hFB, 8'h6F, 8'h79, 8'h83};

    output_voltage_setpoint_select #(.CODE_W(8)) uut (.*);
    output_voltage_far_side #(.RAMP_CYC(6)) farSide (.*);
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic pair_ok(input logic [3:0] b, input logic [1:0] s);
        return b == 4'h0 || ((b <= 4'hC) == (s inside {2'h1, 2'h2}));
    endfunction
    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic ack);
        @(negedge clk);
        {regWrStb, regAddr, regWrData} = {1'b1, a, d};
        #1 chk({8'h00, regAck}, {8'h00, ack});
        @(negedge clk);
        regWrStb = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        {regRdStb, regAddr} = {1'b1, a};
        @(negedge clk);
        regRdStb = 1'b0;
        chk({1'b0, regRdData}, {1'b0, exp});
    endtask
    task automatic sp(input logic [8:0] exp);
        repeat (3) @(negedge clk);
        chk(setpointCode, exp);
    endtask
    // Long enough for sync, ramp and the run phase to settle
    task automatic enable(input logic lvl);
        @(negedge clk);
        enPin = lvl;
        repeat (16) @(negedge clk);
    endtask
    task automatic complete_run();
        $display("comparisons %0d, mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        #100000;
        fails++;
        complete_run();
    end
    initial begin
        {nrst, enPin, regWrStb, regRdStb, storeAllStb, regAddr, regWrData} = '0;
        seed = 32'h5710;
        repeat (20) @(negedge clk);
        nrst = 1'b1;
        rd(8'hA0, 8'h00);
        rd(8'hA6, 8'h01);
        rd(8'hC2, 8'h10);
        rd(8'h55, 8'h00);
        $display("test reset done");
        for (int b = 0; b < 16; b++) begin
            for (int s = 0; s < 4; s++) begin
                wr(8'hC2, {2'b00, 2'(s), 4'(b)}, pair_ok(4'(b), 2'(s)));
                if (pair_ok(4'(b), 2'(s))) begin
                    @(negedge clk);
                    chk({1'b0, linkBootCode}, {1'b0, BOOT_CODE[b]});
                    chk({8'h00, step10mV}, {8'h00, s == 0 || s == 3});
                    chk({8'h00, divQuarter}, {8'h00, s == 0 || s == 3});
                end
            end
        end
        $display("test boot pairing done");
        wr(8'hC2, 8'h15, 1'b1);
        farSide.send(2, 9'h002);
        sp(9'h08D);
        wr(8'hA8, 8'h04, 1'b0);
        wr(8'hA6, 8'h40, 1'b1);
        rd(8'hA6, 8'h01);
        enable(1'b1);
        sp(9'h08F);
        for (int i = 0; i < 6; i++) begin
            r = xs();
            farSide.send(i % 2, {1'b0, r[7:0]});
            e = {1'b0, r[7:0]} + 9'h002;
            sp(e > 9'h0FF ? 9'h0FF : e);
        end
        farSide.send(0, 9'h0A0);
        farSide.send(3, 9'h091);
        sp(9'h091);
        farSide.send(3, 9'h1FF);
        farSide.send(2, 9'h005);
        sp(9'h0A5);
        farSide.send(0, 9'h002);
        farSide.send(2, 9'h0FB);
        sp(9'h000);
        wr(8'hA0, 8'h02, 1'b1);
        rd(8'hA0, 8'h02);
        $display("test link only done");
        enable(1'b0);
        enable(1'b1);
        rd(8'hA0, 8'h0A);
        wr(8'hC2, 8'h3D, 1'b1);
        for (int i = 0; i < 6; i++) begin
            r = xs();
            v = r[7:0] | 8'h01;
            wr(8'hA6, v, 1'b1);
            wr(8'hA8, {5'h00, r[10:8]}, 1'b1);
            sp({1'b0, v} + {6'h00, r[10:8]});
        end
        farSide.send(0, 9'h030);
        farSide.send(2, 9'h010);
        sp({1'b0, v} + {6'h00, r[10:8]});
        wr(8'hA6, 8'h00, 1'b0);
        wr(8'hA6, 8'hFF, 1'b1);
        wr(8'hA8, 8'h7F, 1'b1);
        sp(9'h17E);
        @(negedge clk);
        storeAllStb = 1'b1;
        @(negedge clk);
        storeAllStb = 1'b0;
        chk({5'h00, nvmBootOut}, 9'h00D);
        chk({1'b0, nvmVoutCmdOut}, 9'h0FF);
        $display("test host only done");
        wr(8'hA0, 8'h01, 1'b1);
        wr(8'hA8, 8'h03, 1'b1);
        enable(1'b0);
        enable(1'b1);
        farSide.send(0, 9'h070);
        sp(9'h073);
        wr(8'hA8, 8'h10, 1'b1);
        sp(9'h073);
        farSide.send(2, 9'h020);
        wr(8'hA6, 8'h55, 1'b1);
        sp(9'h073);
        enable(1'b0);
        enable(1'b1);
        farSide.send(0, 9'h070);
        sp(9'h080);
        $display("test mixed done");
        enable(1'b0);
        wr(8'hC2, 8'h10, 1'b1);
        farSide.reload();
        @(negedge clk);
        rd(8'hC2, 8'h3D);
        chk({1'b0, linkBootCode}, 9'h06F);
        rd(8'hA6, 8'hFF);
        wr(8'hA0, 8'h03, 1'b1);
        enable(1'b1);
        sp(9'h10F);
        $display("test reload done");
        complete_run();
    end
endmodule
